// ===== src/aft_pkg.sv
// Constants, register map and types of the frame and burst timing block
package aft_pkg;
   // APB byte addresses
   localparam logic [7:0] AFT_CTRL_ADDR = 8'h20;
   localparam logic [7:0] AFT_FRAME_PERIOD_ADDR = 8'h24;
   localparam logic [7:0] AFT_BURST_SPACING_ADDR = 8'h28;
   localparam logic [7:0] AFT_FRAME_MAX_ADDR = 8'h2c;
   localparam logic [7:0] AFT_FRAME_COUNT_ADDR = 8'h30;
   localparam logic [7:0] AFT_STATUS_ADDR = 8'h38;
   localparam logic [7:0] AFT_MASK_ADDR = 8'h3c;
   // Reset values
   localparam logic [31:0] AFT_REG_RESET = 32'h0000_0000;
   // Control register fields
   localparam int AFT_SRC_LSB = 0;
   localparam int AFT_CNT_SYNC_BIT = 5;
   localparam int AFT_TMR_SYNC_BIT = 6;
   localparam int AFT_BURST_EN_BIT = 8;
   localparam int AFT_FIRST_LSB = 12;
   localparam int AFT_LAST_LSB = 16;
   localparam logic [31:0] AFT_CTRL_WMASK = 32'h000f_f16f;
   // Sample source codes
   localparam logic [3:0] AFT_SRC_LEGACY = 4'h0;
   localparam logic [3:0] AFT_SRC_TIMER = 4'h1;
   // Status and mask bit positions
   localparam int AFT_ST_FRAME = 0;
   localparam int AFT_ST_BURST = 1;
   localparam int AFT_ST_TC = 2;
   localparam int AFT_ST_W = 3;
   // Timing
   localparam int AFT_CLK_NS = 20;
   localparam int AFT_TICK_NS = 25;
   localparam int AFT_MIN_SPACING_NS = 5000;
   localparam int AFT_MIN_SPACING_TICKS =
      (AFT_MIN_SPACING_NS + AFT_TICK_NS - 1) / AFT_TICK_NS;
   // Sequencer states
   typedef enum logic [0:0] {
      AFT_SEQ_IDLE = 1'b0,
      AFT_SEQ_WAIT = 1'b1
   } aft_seq_t;
endpackage : aft_pkg

// ===== src/aft_timing.sv
// Frame timer, burst sequencer and frame counter with an APB register file
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
module aft_timing #(
   parameter int CHAN_W = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Events from neighbouring units, same clock
   input wire logic trig_start,
   input wire logic ext_sample_req,
   // Sampling outputs
   output logic sample_strobe,
   output logic [CHAN_W-1:0] sample_channel,
   output logic burst_active,
   output logic frame_event,
   output logic terminal_count,
   // Interrupt
   output logic irq
);
   import aft_pkg::*;

   generate
      if (CHAN_W < 1 || CHAN_W > 4) begin : g_bad_chan_w
         $error("CHAN_W must lie between 1 and 4");
      end
   endgenerate

   // Byte-lane merge, shared by the four 32-bit configuration registers
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
         input logic [31:0] new_v, input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge_bytes

   ////////////////////////////////////////////////////////////////////////
   // Register state
   logic [31:0] ctrl_r;
   logic [31:0] frame_period_r;
   logic [31:0] burst_spacing_r;
   logic [31:0] frame_max_r;
   logic [31:0] frame_count_r;
   logic [AFT_ST_W-1:0] status_r;
   logic [AFT_ST_W-1:0] mask_r;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic irq_r;

   logic [3:0] src_sel;
   logic cnt_sync;
   logic tmr_sync;
   logic burst_en;
   logic [CHAN_W-1:0] first_chan;
   logic [CHAN_W-1:0] last_chan;
   logic wr_en;
   logic addr_ok;

   assign src_sel = ctrl_r[AFT_SRC_LSB +: 4];
   assign cnt_sync = ctrl_r[AFT_CNT_SYNC_BIT];
   assign tmr_sync = ctrl_r[AFT_TMR_SYNC_BIT];
   assign burst_en = ctrl_r[AFT_BURST_EN_BIT];
   assign first_chan = ctrl_r[AFT_FIRST_LSB +: CHAN_W];
   assign last_chan = ctrl_r[AFT_LAST_LSB +: CHAN_W];
   // Write lands only on the edge where the access phase completes
   assign wr_en = psel && penable && pready_r && pwrite;

   // Decode of mapped addresses
   always_comb begin
      case (paddr)
         AFT_CTRL_ADDR, AFT_FRAME_PERIOD_ADDR, AFT_BURST_SPACING_ADDR,
         AFT_FRAME_MAX_ADDR, AFT_FRAME_COUNT_ADDR, AFT_STATUS_ADDR,
         AFT_MASK_ADDR: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // APB handshake: one wait-free access cycle, answer built in setup
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= AFT_REG_RESET;
      end else begin
         pready_r <= psel && !penable && !pready_r;
         if (psel && !penable) begin
            pslverr_r <= !addr_ok;
            case (paddr)
               AFT_CTRL_ADDR: prdata_r <= ctrl_r;
               AFT_FRAME_PERIOD_ADDR: prdata_r <= frame_period_r;
               AFT_BURST_SPACING_ADDR: prdata_r <= burst_spacing_r;
               AFT_FRAME_MAX_ADDR: prdata_r <= frame_max_r;
               AFT_FRAME_COUNT_ADDR: prdata_r <= frame_count_r;
               AFT_STATUS_ADDR: prdata_r <= {29'h0, status_r};
               AFT_MASK_ADDR: prdata_r <= {29'h0, mask_r};
               default: prdata_r <= AFT_REG_RESET;
            endcase
         end else begin
            pslverr_r <= 1'b0;
         end
      end
   end

   // Software-written configuration, byte lanes honoured
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl_r <= AFT_REG_RESET;
         frame_period_r <= AFT_REG_RESET;
         burst_spacing_r <= AFT_REG_RESET;
         frame_max_r <= AFT_REG_RESET;
         mask_r <= '0;
      end else if (wr_en) begin
         case (paddr)
            AFT_CTRL_ADDR: ctrl_r <=
               merge_bytes(ctrl_r, pwdata, pstrb) & AFT_CTRL_WMASK;
            AFT_FRAME_PERIOD_ADDR: frame_period_r <=
               merge_bytes(frame_period_r, pwdata, pstrb);
            AFT_BURST_SPACING_ADDR: burst_spacing_r <=
               merge_bytes(burst_spacing_r, pwdata, pstrb);
            AFT_FRAME_MAX_ADDR: frame_max_r <=
               merge_bytes(frame_max_r, pwdata, pstrb);
            AFT_MASK_ADDR: if (pstrb[0]) begin
               mask_r <= pwdata[AFT_ST_W-1:0];
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // 40 MHz tick from 50 MHz: four enables in every five clocks
   logic [5:0] tick_acc_r;
   logic [5:0] tick_sum;
   logic tick;
   assign tick_sum = tick_acc_r + 6'(AFT_CLK_NS);
   assign tick = tick_sum >= 6'(AFT_TICK_NS);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         tick_acc_r <= '0;
      end else if (tick) begin
         tick_acc_r <= tick_sum - 6'(AFT_TICK_NS);
      end else begin
         tick_acc_r <= tick_sum;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame timer; period is compared on every tick, so a write applies at once
   logic [31:0] frame_tmr_r;
   logic frame_evt_r;
   logic timer_src;
   assign timer_src = src_sel == AFT_SRC_TIMER;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         frame_tmr_r <= '0;
         frame_evt_r <= 1'b0;
      end else if (!timer_src) begin
         frame_tmr_r <= '0;
         frame_evt_r <= 1'b0;
      end else if (trig_start && tmr_sync) begin
         frame_tmr_r <= '0;
         frame_evt_r <= 1'b1;
      end else if (tick && frame_tmr_r >= frame_period_r) begin
         frame_tmr_r <= '0;
         frame_evt_r <= 1'b1;
      end else begin
         frame_evt_r <= 1'b0;
         if (tick) begin
            frame_tmr_r <= frame_tmr_r + 32'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Burst request latch; a request in the start cycle is kept
   logic req;
   logic pend_r;
   logic start;
   assign req = timer_src ? frame_evt_r : ext_sample_req;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         pend_r <= 1'b0;
      end else begin
         pend_r <= req || (pend_r && !start);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Spacing limit in ticks; legacy ignores the burst value
   logic [32:0] spc_limit;
   always_comb begin
      if (src_sel == AFT_SRC_LEGACY) begin
         spc_limit = 33'(AFT_MIN_SPACING_TICKS);
      end else begin
         spc_limit = {1'b0, burst_spacing_r}
            + 33'(AFT_MIN_SPACING_TICKS);
      end
   end

   // Sequencer: one sample at start, then one per elapsed spacing until last_chan; the final spacing ends the burst
   aft_seq_t seq_r;
   logic [32:0] spc_cnt_r;
   logic [CHAN_W-1:0] chan_r;
   logic strobe_r;
   logic burst_done_r;
   logic spc_done;
   logic next_chan;
   logic count_step;

   assign spc_done = tick && (spc_cnt_r + 33'h1 >= spc_limit);
   assign next_chan = burst_en && chan_r < last_chan;
   assign start = pend_r && (seq_r == AFT_SEQ_IDLE ||
      (spc_done && !next_chan));

   always_ff @(posedge clk) begin
      if (!resetn) begin
         seq_r <= AFT_SEQ_IDLE;
         spc_cnt_r <= '0;
         chan_r <= '0;
         strobe_r <= 1'b0;
         burst_done_r <= 1'b0;
      end else begin
         strobe_r <= 1'b0;
         burst_done_r <= 1'b0;
         case (seq_r)
            AFT_SEQ_IDLE: begin
               if (start) begin
                  seq_r <= AFT_SEQ_WAIT;
                  chan_r <= first_chan;
                  strobe_r <= 1'b1;
                  spc_cnt_r <= '0;
               end
            end
            AFT_SEQ_WAIT: begin
               if (spc_done) begin
                  spc_cnt_r <= '0;
                  if (next_chan) begin
                     chan_r <= chan_r + 1'b1;
                     strobe_r <= 1'b1;
                  end else begin
                     burst_done_r <= 1'b1;
                     if (start) begin
                        chan_r <= first_chan;
                        strobe_r <= 1'b1;
                     end else begin
                        seq_r <= AFT_SEQ_IDLE;
                     end
                  end
               end else if (tick) begin
                  spc_cnt_r <= spc_cnt_r + 33'h1;
               end
            end
            default: seq_r <= AFT_SEQ_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame counter and terminal count
   logic tc_r;
   assign count_step = burst_en ? start
      : (start || (spc_done && next_chan));

   always_ff @(posedge clk) begin
      if (!resetn) begin
         frame_count_r <= '0;
         tc_r <= 1'b0;
      end else if (trig_start && cnt_sync) begin
         frame_count_r <= '0;
         tc_r <= 1'b0;
      end else if (count_step) begin
         frame_count_r <= frame_count_r + 32'h1;
         tc_r <= frame_count_r + 32'h1 == frame_max_r;
      end else begin
         tc_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sticky status, write one to clear; a new event beats the clear
   logic [AFT_ST_W-1:0] st_set;
   logic [AFT_ST_W-1:0] st_clr;
   always_comb begin
      st_set = '0;
      st_set[AFT_ST_FRAME] = frame_evt_r;
      st_set[AFT_ST_BURST] = burst_done_r;
      st_set[AFT_ST_TC] = tc_r;
      st_clr = '0;
      if (wr_en && paddr == AFT_STATUS_ADDR && pstrb[0]) begin
         st_clr = pwdata[AFT_ST_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         status_r <= '0;
         irq_r <= 1'b0;
      end else begin
         status_r <= (status_r & ~st_clr) | st_set;
         irq_r <= |(((status_r & ~st_clr) | st_set) & mask_r);
      end
   end

   // Outputs straight from flops
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign sample_strobe = strobe_r;
   assign sample_channel = chan_r;
   assign burst_active = seq_r == AFT_SEQ_WAIT;
   assign frame_event = frame_evt_r;
   assign terminal_count = tc_r;
   assign irq = irq_r;
endmodule : aft_timing

// ===== verification/aft_timing_checker.sv
// Port-level checks of the frame and burst timing block
`timescale 1ns/10ps
module aft_timing_checker #(
   parameter int CHAN_W = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Bus handshake
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // Sampling and events
   input wire logic sample_strobe,
   input wire logic [CHAN_W-1:0] sample_channel,
   input wire logic burst_active,
   input wire logic frame_event,
   input wire logic terminal_count
);
   logic [9:0] gap_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////
   // Clocks since the last strobe; saturated so the first one passes
   always_ff @(posedge clk) begin
      if (!resetn) gap_r <= 10'h3ff;
      else if (sample_strobe) gap_r <= 10'h001;
      else if (gap_r != 10'h3ff) gap_r <= gap_r + 10'h001;
   end
   ////////////////////////////////////////////////////////////////////////
   chk_ready_answer: assert property (
      psel && !penable |=> pready)
      else $error("no ready after setup");
   chk_ready_single: assert property (
      pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_err_ready: assert property (
      pslverr |-> pready)
      else $error("error without ready");
   chk_strobe_single: assert property (
      sample_strobe |=> !sample_strobe)
      else $error("strobe longer than one cycle");
   chk_strobe_busy: assert property (
      sample_strobe |-> burst_active)
      else $error("strobe outside a burst");
   chk_strobe_gap: assert property (
      sample_strobe |-> gap_r >= 10'd248)
      else $error("samples closer than minimum spacing");
   chk_chan_hold: assert property (
      !sample_strobe |-> $stable(sample_channel))
      else $error("channel moved without strobe");
   chk_tc_single: assert property (
      terminal_count |=> !terminal_count)
      else $error("terminal count longer than one cycle");
   // Main scenarios reached
   cover property (terminal_count);
   cover property (frame_event);
   cover property (pslverr);
endmodule : aft_timing_checker

bind aft_timing aft_timing_checker #(.CHAN_W(CHAN_W)) u_chk (
   .clk(clk),
   .resetn(resetn),
   .psel(psel),
   .penable(penable),
   .pready(pready),
   .pslverr(pslverr),
   .sample_strobe(sample_strobe),
   .sample_channel(sample_channel),
   .burst_active(burst_active),
   .frame_event(frame_event),
   .terminal_count(terminal_count)
);

// ===== verification/aft_trig_model.sv
// Trigger and sample request source beside the timing block
`timescale 1ns/10ps
module aft_trig_model (
   // Clock
   input wire logic clk,
   // Event pulses
   output logic trig_start,
   output logic ext_sample_req
);
   initial begin
      trig_start = 1'b0;
      ext_sample_req = 1'b0;
   end
   // One-cycle pulse launched after an edge; t picks the trigger line
   task automatic pulse(bit t);
      @(posedge clk);
      if (t) trig_start <= 1'b1;
      else ext_sample_req <= 1'b1;
      @(posedge clk);
      trig_start <= 1'b0;
      ext_sample_req <= 1'b0;
   endtask : pulse
endmodule : aft_trig_model

// ===== verification/test_aft_timing.sv
// Self-checking bench for the frame and burst timing block
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
   n_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module test_aft_timing;
   import aft_pkg::*;
   logic clk, resetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, v;
   logic [3:0] pstrb, sample_channel, cexp;
   logic trig_start, ext_sample_req, sample_strobe, burst_active;
   logic frame_event, terminal_count, irq;
   logic [32:0] rq[$], rexp;
   logic [3:0] cq[$];
   int st[$], fe[$], cyc, t0, n_errors, total_checks;
   aft_timing #(.CHAN_W(4)) dut_u (.clk(clk), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .trig_start(trig_start),
      .ext_sample_req(ext_sample_req), .sample_strobe(sample_strobe),
      .sample_channel(sample_channel), .burst_active(burst_active),
      .frame_event(frame_event), .terminal_count(terminal_count),
      .irq(irq));
   aft_trig_model u_src (.clk(clk), .trig_start(trig_start),
      .ext_sample_req(ext_sample_req));
   ////////////////////////////////////////////////////////////////////////
   // Clock, cycle count by NBA so every reader sees the same value
   always #10 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   // Results are matched against the oldest note when they appear
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         rexp = rq.pop_front();
         `CHK("rdata", rexp, {pslverr, prdata})
      end
      if (sample_strobe === 1'b1) begin
         st.push_back(cyc);
         cexp = cq.pop_front();
         `CHK("channel", cexp, sample_channel)
      end
      if (frame_event === 1'b1) fe.push_back(cyc);
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic apb(bit w, logic [7:0] a, logic [31:0] d,
      logic [3:0] s);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      // A slave that never answers counts against the run
      if (pready !== 1'b1) begin
         n_errors++;
         $display("BAD pready exp 1 got %b", pready);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(logic [7:0] a, logic [32:0] e);
      rq.push_back(e);
      apb(1'b0, a, 32'h0, 4'hf);
   endtask : rd
   task automatic wr(logic [7:0] a, logic [31:0] d);
      apb(1'b1, a, d, 4'hf);
   endtask : wr
   // Tick phase against the bus clock allows one clock of jitter
   task automatic near(string n, int e, int g);
      `CHK(n, 1'b1, (g >= e - 1 && g <= e + 1))
   endtask : near
   task automatic burst3();
      for (int i = 1; i < 4; i++) cq.push_back(4'(i));
   endtask : burst3
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////
   // Watchdog, far beyond the few thousand cycles the tests need
   initial begin
      #400000;
      n_errors++;
      end_sim();
   end
   // Main sequence
   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      {cyc, n_errors, total_checks} = '0;
      v = $urandom(32'h38fa);
      // Idle bus fields are random, so nothing may lean on them
      pwrite = v[0];
      paddr = v[15:8];
      pwdata = $urandom();
      pstrb = v[19:16];
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd(AFT_FRAME_PERIOD_ADDR, {1'b0, AFT_REG_RESET});
      rd(AFT_BURST_SPACING_ADDR, {1'b0, AFT_REG_RESET});
      rd(AFT_FRAME_MAX_ADDR, {1'b0, AFT_REG_RESET});
      rd(8'h40, 33'h1_0000_0000);
      // Lanes that are off carry the inverse, so strobes must gate them
      v = $urandom() >> 1;
      for (int i = 0; i < 4; i++)
         apb(1'b1, AFT_FRAME_PERIOD_ADDR, v ^ ~(32'hff << 8 * i), 4'h1 << i);
      rd(AFT_FRAME_PERIOD_ADDR, {1'b0, v});
      v = $urandom() >> 1;
      apb(1'b1, AFT_BURST_SPACING_ADDR, v ^ 32'hffff_0000, 4'h3);
      apb(1'b1, AFT_BURST_SPACING_ADDR, v ^ 32'h0000_ffff, 4'hc);
      rd(AFT_BURST_SPACING_ADDR, {1'b0, v});
      // Top of the documented range; legacy below must ignore it
      wr(AFT_BURST_SPACING_ADDR, 32'h8000_0000);
      rd(AFT_BURST_SPACING_ADDR, 33'h0_8000_0000);
      wr(AFT_FRAME_MAX_ADDR, 32'h8000_0000);
      rd(AFT_FRAME_MAX_ADDR, 33'h0_8000_0000);
      wr(AFT_FRAME_COUNT_ADDR, v);
      rd(AFT_FRAME_COUNT_ADDR, 33'h0);
      // Legacy source, single channel, second request while busy
      wr(AFT_CTRL_ADDR, 32'h0000_3000);
      cq = '{4'h3, 4'h3};
      u_src.pulse(1'b0);
      t0 = cyc;
      repeat (20) @(posedge clk);
      u_src.pulse(1'b0);
      repeat (600) @(posedge clk);
      `CHK("answer", 2, st[0] - t0)
      near("legacy gap", 250, st[1] - st[0]);
      `CHK("no frames", 0, fe.size())
      `CHK("idle", 1'b0, burst_active)
      rd(AFT_FRAME_COUNT_ADDR, 33'd2);
      // Bursts of channels 1..3, next trigger arrives mid-burst
      wr(AFT_BURST_SPACING_ADDR, 32'd40);
      wr(AFT_CTRL_ADDR, 32'h0003_1108);
      burst3();
      burst3();
      u_src.pulse(1'b0);
      repeat (400) @(posedge clk);
      u_src.pulse(1'b0);
      repeat (1900) @(posedge clk);
      for (int i = 2; i < 7; i++) begin
         near("spacing", 300, st[i + 1] - st[i]);
      end
      rd(AFT_FRAME_COUNT_ADDR, 33'd4);
      // Terminal count raises the masked interrupt, cleared by one
      wr(AFT_FRAME_MAX_ADDR, 32'd5);
      wr(AFT_MASK_ADDR, 32'h4);
      burst3();
      u_src.pulse(1'b0);
      repeat (1000) @(posedge clk);
      `CHK("irq", 1'b1, irq)
      rd(AFT_STATUS_ADDR, 33'h6);
      wr(AFT_STATUS_ADDR, 32'h4);
      repeat (2) @(posedge clk);
      `CHK("irq clear", 1'b0, irq)
      wr(AFT_CTRL_ADDR, 32'h0003_1128);
      u_src.pulse(1'b1);
      rd(AFT_FRAME_COUNT_ADDR, 33'h0);
      // Frame timer as source, synced to the trigger
      wr(AFT_FRAME_PERIOD_ADDR, 32'd399);
      wr(AFT_CTRL_ADDR, 32'h0000_0041);
      cq = '{4'h0, 4'h0, 4'h0};
      u_src.pulse(1'b1);
      t0 = cyc;
      repeat (1100) @(posedge clk);
      `CHK("sync", 1, fe[0] - t0)
      near("frame", 500, fe[1] - fe[0]);
      `CHK("frames", 3, fe.size())
      // Period below the minimum: the sample spacing throttles the rate
      wr(AFT_FRAME_PERIOD_ADDR, 32'h0);
      cq = '{4'h0, 4'h0, 4'h0};
      repeat (900) @(posedge clk);
      `CHK("throttled", 17, st.size())
      for (int i = 14; i < 16; i++) begin
         near("throttle", 300, st[i + 1] - st[i]);
      end
      end_sim();
   end
endmodule : test_aft_timing
